//--- rtl/monitor_break_pkg.sv
// constants shared by the breakpoint and interrupt-combining logic
// assumes a 16-bit processor address bus and an 8-bit data bus
package monitor_break_pkg;
	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	localparam int         ADDR_W         = 16;
	localparam int         DATA_W         = 8;
	localparam int         BLOCK_LSB      = 13;
	localparam int         PAGE_LSB       = 12;
	localparam int         LIMIT_LSB      = 9;
	localparam int         LIMIT_W        = 7;
	localparam int         BLOCK_SEL_W    = 3;
	localparam logic [3:0] LOW_HALF_PAGE  = 4'hC;
	localparam logic [3:0] HIGH_HALF_PAGE = 4'hD;

	// ----------------------------------------------------------------
	// break-status byte layout
	// ----------------------------------------------------------------
	localparam int ST_RAM_BIT      = 0;
	localparam int ST_BUFFER_FULL  = 1;
	localparam int ST_PROT_WRITE   = 2;
	localparam int ST_PROGRAM_BRK  = 3;
	localparam int ST_DATA_BRK     = 4;
	localparam int ST_SINGLE_STEP  = 5;
	localparam int ST_SINGLE_CYCLE = 6;
	localparam int ST_RESET_LATCH  = 7;

	// ----------------------------------------------------------------
	// reset values and counts
	// ----------------------------------------------------------------
	localparam logic       RAM_RESET_BIT  = 1'b1;
	localparam logic       RESET_LATCH_INIT = 1'b0;
	localparam logic [7:0] ZERO_OPCODE    = 8'h00;
	localparam logic [7:0] IDLE_DATA      = 8'h00;
	localparam int         COUNT_W        = 4;
	localparam logic [3:0] COUNT_ZERO     = 4'h0;
	localparam logic [3:0] COUNT_ONE      = 4'h1;
endpackage

//--- rtl/monitor_breakpoint_logic.sv
// breakpoint RAM, break flags, instruction cycle counter, forced zero
// opcode, write protection and break-status readback for a monitor.
// assumes all inputs are synchronous to CLOCK and that an external
// lookup ROM presents the bus-cycle count of the fetched opcode.
//
// Summary of operation
// R1: any_break is the OR of the three break flags; gates outputs and forcing.
// R2: interrupt zero is OR of protected write, buffer full and break flags.
// R3: hit only when access is in the assigned block and bit marks breakpoint.
// R4: breakpoint RAM bit reads low for a marked address, high otherwise.
// R5: block select goes low for accesses inside the assigned 8K block.
// R6: controller pulses clear-break low; while low, interrupt logic resets.
// R7: bus command strobe is low when code read, write or read is low.
// R8: data-access breaks only while data break enable is low.
// R9: program-fetch breaks only while program break enable is low.
// R10: single-step enable low raises single-step break after each instruction.
// R11: valid fetch high only on first byte of executed instruction.
// R12: cycle counter done goes low once the preloaded count decrements to zero.
// R13: latch single-cycle flag when breaking instruction takes one cycle.
// R14: forced opcode drives an all-zero byte onto the data bus.
// R15: protected write flag goes low on write into protected region.
// R16: RAM write enable is the active-low write strobe ORed with the limit comparator.
// R17: protected region spans address zero up to the seven-bit limit.
// R18: status read strobe low places the break-status byte on the bus.
// R19: breakpoint write strobe writes the RAM and releases the reset latch.
// R20: two active-low half selects pick lower or upper breakpoint RAM half.
// R21: system reset drives the reset latch low to start from the monitor.
// R22: keyboard controller buffer full interrupts the processor.
// R23: processor writes byte address on low lines, bit on data bit zero.
// R24: status bits: RAM bit, full, protect, prog, data, step, single, latch.
// R25: clear-break also resets forcing logic and the protected write flag.
// R26: data breaks always force zero; others only with single-cycle flag.
// R27: flags are clocked registers, strobes edge detected, reset clears all.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module monitor_breakpoint_logic #(
	parameter int INDEX_W = 13
) (
	input  wire logic        CLOCK,
	input  wire logic        RESET,
	input  wire logic        CLOCK_ENABLE,
	input  wire logic [15:0] ADDRESS,
	input  wire logic [7:0]  DATA_IN,
	output logic      [7:0]  DATA_OUT,
	output logic             DATA_OE_N,
	input  wire logic        BUFFERED_CODE_READ_N,
	input  wire logic        WRITE_N,
	input  wire logic        READ_N,
	input  wire logic        DATA_BREAK_ENABLE_N,
	input  wire logic        PROGRAM_BREAK_ENABLE_N,
	input  wire logic        SINGLE_STEP_ENABLE_N,
	input  wire logic        CLEAR_BREAK_N,
	input  wire logic        KEYBOARD_CTRL_BUFFER_FULL,
	input  wire logic [6:0]  PROTECT_LIMIT,
	input  wire logic [2:0]  BREAK_BLOCK,
	input  wire logic [3:0]  OPCODE_CYCLES,
	output logic             BUS_COMMAND_N,
	output logic             BREAK_BLOCK_SELECT_N,
	output logic             BREAKPOINT_HIT,
	output logic             BREAK_RAM_BIT,
	output logic             LOW_BREAK_HALF_SEL_N,
	output logic             HIGH_BREAK_HALF_SEL_N,
	output logic             READ_BREAK_STATUS_N,
	output logic             WRITE_BREAK_MEM_N,
	output logic             RAM_WRITE_N,
	output logic             PROTECTED_WRITE_FLAG_N,
	output logic             DATA_ACCESS_BREAK,
	output logic             PROGRAM_FETCH_BREAK,
	output logic             SINGLE_STEP_BREAK,
	output logic             ANY_BREAK,
	output logic             SINGLE_CYCLE_OPCODE,
	output logic             FORCE_ZERO_OPCODE,
	output logic             VALID_FETCH,
	output logic             CYCLE_COUNT_DONE_N,
	output logic             RESET_LATCH_N,
	output logic             CPU_INTERRUPT_ZERO
);
	localparam int DEPTH = 1 << INDEX_W;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic               break_ram [DEPTH];
	logic               prev_cmd_n;
	logic               cyc_fetch;
	logic               cyc_data;
	logic               ram_bit;
	logic               data_brk;
	logic               prog_brk;
	logic               step_brk;
	logic               single_cycle;
	logic               force_zero;
	logic               force_done;
	logic               prot_write;
	logic               reset_latch_n;
	logic [3:0]         count;
	logic               in_sync;
	logic [7:0]         data_out;
	logic               data_oe_n;

	logic               next_prev_cmd_n;
	logic               next_cyc_fetch;
	logic               next_cyc_data;
	logic               next_ram_bit;
	logic               next_data_brk;
	logic               next_prog_brk;
	logic               next_step_brk;
	logic               next_single_cycle;
	logic               next_force_zero;
	logic               next_force_done;
	logic               next_prot_write;
	logic               next_reset_latch_n;
	logic [3:0]         next_count;
	logic               next_in_sync;
	logic [7:0]         next_data_out;
	logic               next_data_oe_n;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic               bus_cmd_n;
	logic               cycle_start;
	logic               cycle_end;
	logic               block_match;
	logic               hit;
	logic               low_sel;
	logic               high_sel;
	logic               bp_write;
	logic               status_read;
	logic               protected_addr;
	logic               any_brk;
	logic               clearing;
	logic               valid_fetch;
	logic               data_access;
	logic [INDEX_W-1:0] watch_index;
	logic [INDEX_W-1:0] write_index;
	logic [7:0]         status;

	always_comb begin
		bus_cmd_n   = BUFFERED_CODE_READ_N & WRITE_N & READ_N; // see R7
		cycle_start = prev_cmd_n & ~bus_cmd_n; // see R27
		cycle_end   = ~prev_cmd_n & bus_cmd_n;
		data_access = ~READ_N | ~WRITE_N;
		// see R5
		block_match = ADDRESS[15:monitor_break_pkg::BLOCK_LSB]
			== BREAK_BLOCK;
		watch_index = ADDRESS[INDEX_W-1:0];
		hit         = block_match & ~break_ram[watch_index]; // see R3
		// see R20
		low_sel  = ADDRESS[15:monitor_break_pkg::PAGE_LSB]
			== monitor_break_pkg::LOW_HALF_PAGE;
		high_sel = ADDRESS[15:monitor_break_pkg::PAGE_LSB]
			== monitor_break_pkg::HIGH_HALF_PAGE;
		// see R23
		write_index = {high_sel, ADDRESS[INDEX_W-2:0]};
		bp_write    = (low_sel | high_sel) & ~WRITE_N;
		status_read = (low_sel | high_sel) & ~READ_N;
		// see R17
		protected_addr = ADDRESS[15:monitor_break_pkg::LIMIT_LSB]
			<= PROTECT_LIMIT;
		any_brk     = data_brk | prog_brk | step_brk; // see R1
		// the reset latch holds clear-break active after a system reset
		clearing    = ~CLEAR_BREAK_N | ~reset_latch_n; // see R6
		// see R11
		valid_fetch = ~BUFFERED_CODE_READ_N & in_sync
			& (count == monitor_break_pkg::COUNT_ZERO);
		// see R24
		status = '0;
		status[monitor_break_pkg::ST_RAM_BIT]      = ram_bit;
		status[monitor_break_pkg::ST_BUFFER_FULL]  =
			KEYBOARD_CTRL_BUFFER_FULL;
		status[monitor_break_pkg::ST_PROT_WRITE]   = prot_write;
		status[monitor_break_pkg::ST_PROGRAM_BRK]  = prog_brk;
		status[monitor_break_pkg::ST_DATA_BRK]     = data_brk;
		status[monitor_break_pkg::ST_SINGLE_STEP]  = step_brk;
		status[monitor_break_pkg::ST_SINGLE_CYCLE] = single_cycle;
		status[monitor_break_pkg::ST_RESET_LATCH]  = reset_latch_n;
	end


	// ----------------------------------------------------------------
	// next values
	// ----------------------------------------------------------------
	always_comb begin
		next_prev_cmd_n    = bus_cmd_n;
		next_cyc_fetch     = cyc_fetch;
		next_cyc_data      = cyc_data;
		next_ram_bit       = ram_bit;
		next_data_brk      = data_brk;
		next_prog_brk      = prog_brk;
		next_step_brk      = step_brk;
		next_single_cycle  = single_cycle;
		next_force_zero    = force_zero;
		next_force_done    = force_done;
		next_prot_write    = prot_write;
		next_reset_latch_n = reset_latch_n;
		next_count         = count;
		next_in_sync       = in_sync;
		next_data_out      = monitor_break_pkg::IDLE_DATA;
		next_data_oe_n     = 1'b1;

		if (cycle_start) begin
			next_cyc_fetch = ~BUFFERED_CODE_READ_N;
			next_cyc_data  = data_access;
			// RAM is not read while a breakpoint write owns it
			if (!bp_write)
				next_ram_bit = break_ram[watch_index]; // see R4
			if (hit && data_access && !DATA_BREAK_ENABLE_N)
				next_data_brk = 1'b1; // see R8
			if (hit && valid_fetch && !PROGRAM_BREAK_ENABLE_N)
				next_prog_brk = 1'b1; // see R9
			if (valid_fetch && !SINGLE_STEP_ENABLE_N)
				next_step_brk = 1'b1; // see R10
			if (!WRITE_N && protected_addr && !bp_write)
				next_prot_write = 1'b1; // see R15
			// the instruction executing now decides the flag
			if (hit && data_access && !DATA_BREAK_ENABLE_N && !any_brk)
				next_single_cycle = count == monitor_break_pkg::COUNT_ZERO
					&& in_sync; // see R13
		end

		if (cycle_end) begin
			if (cyc_data) begin
				// a data reference resynchronises after an interrupt
				next_count   = monitor_break_pkg::COUNT_ZERO;
				next_in_sync = 1'b1;
			end else if (count != monitor_break_pkg::COUNT_ZERO) begin
				next_count = count - monitor_break_pkg::COUNT_ONE; // see R12
			end else if (cyc_fetch && in_sync &&
				OPCODE_CYCLES != monitor_break_pkg::COUNT_ZERO) begin
				next_count = OPCODE_CYCLES - monitor_break_pkg::COUNT_ONE;
			end
			if (cyc_fetch && (prog_brk || step_brk) && !force_zero &&
				!force_done)
				next_single_cycle =
					OPCODE_CYCLES == monitor_break_pkg::COUNT_ONE; // see R13
			if (cyc_fetch && force_zero)
				next_force_done = 1'b1;
		end

		// forcing lasts only through the one code read after the break
		next_force_zero = any_brk & ~force_done & ~BUFFERED_CODE_READ_N
			& (data_brk | single_cycle); // see R26
		if (next_force_done)
			next_force_zero = 1'b0;

		// an interrupt entry throws the cycle counter out of step
		if (any_brk)
			next_in_sync = 1'b0;

		if (bp_write)
			next_reset_latch_n = 1'b1; // see R19

		// see R18
		if (status_read) begin
			next_data_out  = status;
			next_data_oe_n = 1'b0;
		end else if (force_zero && !BUFFERED_CODE_READ_N) begin
			next_data_out  = monitor_break_pkg::ZERO_OPCODE; // see R14
			next_data_oe_n = 1'b0;
		end

		// level clear wins over a set in the same cycle
		if (clearing) begin
			next_data_brk     = 1'b0; // see R6
			next_prog_brk     = 1'b0;
			next_step_brk     = 1'b0;
			next_single_cycle = 1'b0;
			next_force_zero   = 1'b0; // see R25
			next_force_done   = 1'b0;
			next_prot_write   = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			prev_cmd_n    <= 1'b1;
			cyc_fetch     <= 1'b0;
			cyc_data      <= 1'b0;
			ram_bit       <= monitor_break_pkg::RAM_RESET_BIT;
			data_brk      <= 1'b0; // see R27
			prog_brk      <= 1'b0;
			step_brk      <= 1'b0;
			single_cycle  <= 1'b0;
			force_zero    <= 1'b0;
			force_done    <= 1'b0;
			prot_write    <= 1'b0;
			reset_latch_n <= monitor_break_pkg::RESET_LATCH_INIT; // see R21
			count         <= monitor_break_pkg::COUNT_ZERO;
			in_sync       <= 1'b0;
			data_out      <= monitor_break_pkg::IDLE_DATA;
			data_oe_n     <= 1'b1;
		end else if (CLOCK_ENABLE) begin
			prev_cmd_n    <= next_prev_cmd_n;
			cyc_fetch     <= next_cyc_fetch;
			cyc_data      <= next_cyc_data;
			ram_bit       <= next_ram_bit;
			data_brk      <= next_data_brk;
			prog_brk      <= next_prog_brk;
			step_brk      <= next_step_brk;
			single_cycle  <= next_single_cycle;
			force_zero    <= next_force_zero;
			force_done    <= next_force_done;
			prot_write    <= next_prot_write;
			reset_latch_n <= next_reset_latch_n;
			count         <= next_count;
			in_sync       <= next_in_sync;
			data_out      <= next_data_out;
			data_oe_n     <= next_data_oe_n;
		end
	end

	// ----------------------------------------------------------------
	// breakpoint RAM, one bit per byte of the assigned block
	// ----------------------------------------------------------------
	generate
		for (genvar i = 0; i < DEPTH; i++) begin : g_bit
			logic next_bit;
			always_comb begin
				next_bit = break_ram[i];
				if (bp_write && write_index == INDEX_W'(i))
					next_bit = DATA_IN[0]; // see R19
			end
			always_ff @(posedge CLOCK) begin
				if (RESET)
					break_ram[i] <= monitor_break_pkg::RAM_RESET_BIT;
				else if (CLOCK_ENABLE)
					break_ram[i] <= next_bit;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign BUS_COMMAND_N          = bus_cmd_n;
	assign BREAK_BLOCK_SELECT_N   = ~block_match;
	assign BREAKPOINT_HIT         = hit;
	assign BREAK_RAM_BIT          = ram_bit;
	assign LOW_BREAK_HALF_SEL_N   = ~low_sel;
	assign HIGH_BREAK_HALF_SEL_N  = ~high_sel;
	assign READ_BREAK_STATUS_N    = ~status_read;
	assign WRITE_BREAK_MEM_N      = ~bp_write;
	assign RAM_WRITE_N            = WRITE_N | protected_addr; // see R16
	assign PROTECTED_WRITE_FLAG_N = ~prot_write;
	assign DATA_ACCESS_BREAK      = data_brk;
	assign PROGRAM_FETCH_BREAK    = prog_brk;
	assign SINGLE_STEP_BREAK      = step_brk;
	assign ANY_BREAK              = any_brk;
	assign SINGLE_CYCLE_OPCODE    = single_cycle;
	assign FORCE_ZERO_OPCODE      = force_zero & any_brk; // see R1
	assign VALID_FETCH            = valid_fetch;
	assign CYCLE_COUNT_DONE_N     = count != monitor_break_pkg::COUNT_ZERO;
	assign RESET_LATCH_N          = reset_latch_n;
	// see R2, R22
	assign CPU_INTERRUPT_ZERO     = prot_write | KEYBOARD_CTRL_BUFFER_FULL
		| any_brk;
	assign DATA_OUT               = data_out;
	assign DATA_OE_N              = data_oe_n;
endmodule // monitor_breakpoint_logic

//--- tb/host_bus_model.sv
// host core bus model: address, data and the three bus strobes
// assumes calls come from a process synchronous to clock; the data bus
// is pulled up, so an undriven bus reads all ones
`timescale 1ns/1ps
module host_bus_model (
	input  wire logic        clock,
	input  wire logic [7:0]  data_out,
	input  wire logic        data_oe_n,
	output logic      [15:0] address,
	output logic      [7:0]  data_in,
	output logic             code_read_n,
	output logic             write_n,
	output logic             read_n
);
	initial begin
		address = 16'h0000;
		data_in = 8'hFF;
		{code_read_n, write_n, read_n} = 3'h7;
	end

	// kind 0 code read, 1 data read, 2 write; len sets a slow strobe
	task automatic cycle(input logic [1:0] kind, input logic [15:0] a,
		input logic [7:0] d, input int len, output logic [7:0] q);
		@(posedge clock);
		address <= a;
		data_in <= d;
		code_read_n <= kind != 2'h0;
		read_n <= kind != 2'h1;
		write_n <= kind != 2'h2;
		repeat (len) @(posedge clock);
		@(negedge clock);
		q = data_oe_n ? 8'hFF : data_out;
		@(posedge clock);
		{code_read_n, write_n, read_n} <= 3'h7;
		// stale data must not look valid once the strobe is gone
		data_in <= ~d;
		@(posedge clock);
		// return at a falling edge so the caller sees settled outputs
		@(negedge clock);
	endtask

	task automatic put(input logic [15:0] a);
		@(posedge clock);
		address <= a;
		@(negedge clock);
	endtask
endmodule // host_bus_model

//--- tb/monitor_break_sva.sv
// concurrent checks on the breakpoint logic, bound to its top ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module monitor_break_sva (
	input wire logic        CLOCK,
	input wire logic        RESET,
	input wire logic        CLOCK_ENABLE,
	input wire logic [15:0] ADDRESS,
	input wire logic        WRITE_N,
	input wire logic        READ_N,
	input wire logic        BUFFERED_CODE_READ_N,
	input wire logic        DATA_BREAK_ENABLE_N,
	input wire logic        CLEAR_BREAK_N,
	input wire logic        KEYBOARD_CTRL_BUFFER_FULL,
	input wire logic [6:0]  PROTECT_LIMIT,
	input wire logic [2:0]  BREAK_BLOCK,
	input wire logic [7:0]  DATA_OUT,
	input wire logic        DATA_OE_N,
	input wire logic        BUS_COMMAND_N,
	input wire logic        BREAK_BLOCK_SELECT_N,
	input wire logic        BREAKPOINT_HIT,
	input wire logic        READ_BREAK_STATUS_N,
	input wire logic        VALID_FETCH,
	input wire logic        CYCLE_COUNT_DONE_N,
	input wire logic        WRITE_BREAK_MEM_N,
	input wire logic        RAM_WRITE_N,
	input wire logic        PROTECTED_WRITE_FLAG_N,
	input wire logic        DATA_ACCESS_BREAK,
	input wire logic        PROGRAM_FETCH_BREAK,
	input wire logic        SINGLE_STEP_BREAK,
	input wire logic        ANY_BREAK,
	input wire logic        FORCE_ZERO_OPCODE,
	input wire logic        RESET_LATCH_N,
	input wire logic        CPU_INTERRUPT_ZERO
);
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RESET);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	any_break_or_a: assert property (ANY_BREAK ==
		(DATA_ACCESS_BREAK | PROGRAM_FETCH_BREAK | SINGLE_STEP_BREAK))
		else $error("any break is not the OR of the flags");
	irq_combine_a: assert property (CPU_INTERRUPT_ZERO ==
		(!PROTECTED_WRITE_FLAG_N | KEYBOARD_CTRL_BUFFER_FULL | ANY_BREAK))
		else $error("interrupt line does not match its sources");
	block_select_a: assert property (BREAK_BLOCK_SELECT_N ==
		(ADDRESS[15:13] != BREAK_BLOCK)) else $error("block select wrong");
	bus_cmd_a: assert property (BUS_COMMAND_N ==
		(BUFFERED_CODE_READ_N & WRITE_N & READ_N))
		else $error("bus command strobe wrong");
	hit_in_block_a: assert property (BREAKPOINT_HIT |->
		!BREAK_BLOCK_SELECT_N) else $error("hit outside the block");
	data_gate_a: assert property ($rose(DATA_ACCESS_BREAK) |->
		$past(!DATA_BREAK_ENABLE_N)) else $error("data break not enabled");
	ram_write_a: assert property (RAM_WRITE_N ==
		(WRITE_N | (ADDRESS[15:9] <= PROTECT_LIMIT)))
		else $error("ram write enable wrong");
	clear_flags_a: assert property (!CLEAR_BREAK_N && CLOCK_ENABLE |=>
		!ANY_BREAK && PROTECTED_WRITE_FLAG_N && !FORCE_ZERO_OPCODE)
		else $error("clear did not reset the break logic");
	force_zero_a: assert property (FORCE_ZERO_OPCODE && !DATA_OE_N &&
		!BUFFERED_CODE_READ_N |-> DATA_OUT == monitor_break_pkg::ZERO_OPCODE)
		else $error("forced opcode is not zero");
	latch_release_a: assert property (!WRITE_BREAK_MEM_N &&
		CLOCK_ENABLE |=> RESET_LATCH_N) else $error("latch not released");
	prot_flag_a: assert property ($fell(PROTECTED_WRITE_FLAG_N) |->
		$past(!WRITE_N && ADDRESS[15:9] <= PROTECT_LIMIT))
		else $error("protected flag without a protected write");
	status_sel_a: assert property (READ_BREAK_STATUS_N ==
		(READ_N | (ADDRESS[15:13] != 3'h6)))
		else $error("status read strobe wrong");
	valid_fetch_a: assert property (VALID_FETCH |->
		!BUFFERED_CODE_READ_N && !CYCLE_COUNT_DONE_N)
		else $error("valid fetch outside a counted code read");

	data_break_c: cover property ($rose(DATA_ACCESS_BREAK));
	prog_break_c: cover property ($rose(PROGRAM_FETCH_BREAK));
	prot_write_c: cover property ($fell(PROTECTED_WRITE_FLAG_N));
endmodule // monitor_break_sva

bind monitor_breakpoint_logic monitor_break_sva sva (.*);

//--- tb/monitor_breakpoint_logic_test.sv
// self-checking bench for the breakpoint and interrupt-combining logic
// assumes the host bus model drives the processor side of the bus
`timescale 1ns/1ps
module monitor_breakpoint_logic_test;
	localparam logic [1:0] CODE = 2'h0;
	localparam logic [1:0] RD   = 2'h1;
	localparam logic [1:0] WR   = 2'h2;
	typedef struct {
		logic [15:0] a;
		logic [2:0]  sel;
	} row_t;
	logic        clock     = 1'b0;
	logic        reset     = 1'b1;
	logic        data_en_n = 1'b1;
	logic        prog_en_n = 1'b1;
	logic        clear_n   = 1'b1;
	logic        step_en_n = 1'b1;
	logic        full      = 1'b0;
	logic [3:0]  op_cycles = 4'h1;
	logic [15:0] address;
	logic [7:0]  data_in;
	logic [7:0]  data_out;
	logic [7:0]  q;
	logic        code_n;
	logic        write_n;
	logic        read_n;
	logic        oe_n;
	logic        lo_n;
	logic        hi_n;
	logic        blk_n;
	logic        ram_bit;
	logic        prot_n;
	logic        dbrk;
	logic        pbrk;
	logic        sbrk;
	logic        anyb;
	logic        scyc;
	logic        latch_n;
	logic        irq;
	int          failures  = 0;
	int          n_checks  = 0;
	// {low half, high half, block select}, block 1 is 2000-3FFF
	row_t rows [9] = '{'{16'hC000, 3'h3}, '{16'hCFFF, 3'h3},
		'{16'hD000, 3'h5}, '{16'hDFFF, 3'h5}, '{16'hBFFF, 3'h7},
		'{16'hE000, 3'h7}, '{16'h2000, 3'h6}, '{16'h3FFF, 3'h6},
		'{16'h1FFF, 3'h7}};

	always #5 clock = ~clock;

	host_bus_model host (.clock(clock), .data_out(data_out),
		.data_oe_n(oe_n), .address(address), .data_in(data_in),
		.code_read_n(code_n), .write_n(write_n), .read_n(read_n));

	monitor_breakpoint_logic dut (.CLOCK(clock), .RESET(reset),
		.CLOCK_ENABLE(1'b1), .ADDRESS(address), .DATA_IN(data_in),
		.DATA_OUT(data_out), .DATA_OE_N(oe_n), .WRITE_N(write_n),
		.BUFFERED_CODE_READ_N(code_n), .READ_N(read_n),
		.DATA_BREAK_ENABLE_N(data_en_n), .PROGRAM_BREAK_ENABLE_N(prog_en_n),
		.SINGLE_STEP_ENABLE_N(step_en_n), .CLEAR_BREAK_N(clear_n),
		.KEYBOARD_CTRL_BUFFER_FULL(full), .PROTECT_LIMIT(7'h01),
		.BREAK_BLOCK(3'h1), .OPCODE_CYCLES(op_cycles), .BUS_COMMAND_N(),
		.BREAK_BLOCK_SELECT_N(blk_n), .BREAKPOINT_HIT(),
		.BREAK_RAM_BIT(ram_bit), .LOW_BREAK_HALF_SEL_N(lo_n),
		.HIGH_BREAK_HALF_SEL_N(hi_n), .READ_BREAK_STATUS_N(),
		.WRITE_BREAK_MEM_N(), .RAM_WRITE_N(),
		.PROTECTED_WRITE_FLAG_N(prot_n), .DATA_ACCESS_BREAK(dbrk),
		.PROGRAM_FETCH_BREAK(pbrk), .SINGLE_STEP_BREAK(sbrk),
		.ANY_BREAK(anyb),
		.SINGLE_CYCLE_OPCODE(scyc), .FORCE_ZERO_OPCODE(), .VALID_FETCH(),
		.CYCLE_COUNT_DONE_N(), .RESET_LATCH_N(latch_n),
		.CPU_INTERRUPT_ZERO(irq));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// callers arrive at a falling edge, so the value is settled when taken
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			failures++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask

	task automatic clear_pulse;
		@(posedge clock);
		clear_n <= 1'b0;
		@(posedge clock);
		clear_n <= 1'b1;
		@(negedge clock);
	endtask

	task automatic end_sim;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		@(negedge clock);
		chk(latch_n === 1'b0, "reset latch not low");
		chk(prot_n === 1'b1 && anyb === 1'b0, "flags after reset");
		chk(ram_bit === 1'b1 && irq === 1'b0, "idle after reset");
		$display("test reset done");
		foreach (rows[i]) begin
			host.put(rows[i].a);
			chk({lo_n, hi_n, blk_n} === rows[i].sel, "decode");
		end
		$display("test decode done");
		host.cycle(WR, 16'hC123, 8'hFE, 3, q);
		host.cycle(WR, 16'hD456, 8'h00, 6, q);
		chk(latch_n === 1'b1, "latch not released");
		host.cycle(RD, 16'h2123, 8'hFF, 3, q);
		chk(anyb === 1'b0, "break while disabled");
		@(posedge clock);
		data_en_n <= 1'b0;
		host.cycle(RD, 16'h2124, 8'hFF, 3, q);
		chk(anyb === 1'b0, "break on unmarked byte");
		host.cycle(RD, 16'h2123, 8'hFF, 3, q);
		chk(dbrk === 1'b1 && irq === 1'b1, "data break");
		chk(ram_bit === 1'b0, "ram bit for marked byte");
		host.cycle(CODE, 16'h2200, 8'hFF, 3, q);
		chk(q === 8'h00, "opcode not forced to zero");
		host.cycle(RD, 16'hC000, 8'hFF, 3, q);
		chk((q & 8'hBB) === 8'h91, "status byte");
		clear_pulse();
		chk(anyb === 1'b0 && irq === 1'b0, "clear");
		$display("test data break done");
		@(posedge clock);
		full <= 1'b1;
		@(negedge clock);
		chk(irq === 1'b1, "buffer full interrupt");
		@(posedge clock);
		full <= 1'b0;
		host.cycle(WR, 16'h0400, 8'h55, 3, q);
		chk(prot_n === 1'b1, "write above limit flagged");
		host.cycle(WR, 16'h03FF, 8'h55, 3, q);
		chk(prot_n === 1'b0 && irq === 1'b1, "protected write");
		clear_pulse();
		chk(prot_n === 1'b1, "protected flag not cleared");
		$display("test protection done");
		@(posedge clock);
		data_en_n <= 1'b1;
		prog_en_n <= 1'b0;
		host.cycle(RD, 16'h4000, 8'hFF, 3, q);
		host.cycle(CODE, 16'h3456, 8'hFF, 3, q);
		chk(pbrk === 1'b1 && scyc === 1'b1, "program break");
		$display("test program break done");
		clear_pulse();
		@(posedge clock);
		prog_en_n <= 1'b1;
		step_en_n <= 1'b0;
		op_cycles <= 4'h2;
		host.cycle(RD, 16'h4000, 8'hFF, 3, q);
		host.cycle(CODE, 16'h4100, 8'hFF, 3, q);
		chk(sbrk === 1'b1 && pbrk === 1'b0, "single step");
		chk(scyc === 1'b0 && irq === 1'b1, "multi-cycle step");
		$display("test single step done");
		@(posedge clock);
		reset <= 1'b1;
		@(posedge clock);
		reset <= 1'b0;
		@(negedge clock);
		chk(latch_n === 1'b0 && anyb === 1'b0, "mid-run reset");
		$display("test mid-run reset done");
		end_sim();
	end

	initial begin
		#50000;
		failures++;
		end_sim();
	end
endmodule // monitor_breakpoint_logic_test
